// ==== hw/rbqm_map.vh ====
// Purpose: Address map, field positions and reset values of the record biquad and mixer.
// Assumes: 32-bit APB data, 12-bit byte address, one aligned word per register.
// Notes:   Coefficient windows mirror the byte-register pages; one word holds one coefficient.
`ifndef RBQM_MAP_VH
`define RBQM_MAP_VH

// Control and status words.
`define RBQM_ADDR_CTRL   12'h000
`define RBQM_ADDR_STAT   12'h004
`define RBQM_CTRL_RST    32'h00000008
`define RBQM_ALLOC_LO    2
`define RBQM_ALLOC_HI    3
`define RBQM_SUM_BIT     4
`define RBQM_BANK_BIT    5
`define RBQM_ALLOC_RST   2'h2

// Coefficient pages: paddr[11:7] selects a biquad page, paddr[11:6] the mixer page; the low bits are the byte register.
`define RBQM_PG_A        5'h08
`define RBQM_PG_B        5'h09
`define RBQM_PG_ALT      5'h0A
`define RBQM_BLK_START   7'h08
`define RBQM_ALT_END     7'h44
`define RBQM_MIX_PG      6'h18

// Word indices inside the coefficient memory.
`define RBQM_IDX_PG_B    7'h1E
`define RBQM_IDX_ALT     7'h3C
`define RBQM_IDX_MIX     7'h4B
`define RBQM_IDX_LAST    7'h5A

// Arithmetic constants.
`define RBQM_UNITY       32'h7FFFFFFF
`define RBQM_NCOEF       3'h5
`define RBQM_LAST_COEF   3'h4
`define RBQM_MIX_DONE    5'h10
`define RBQM_NSEC        12

`endif

// ==== hw/rbqm_coef_ram.v ====
// Purpose: Single-port coefficient store for the biquad sections and mixers.
// Assumes: One access per clock; read data appear one edge after the address.
// Notes:   Contents are not reset; the core fills defaults after reset.
`timescale 1ns/1ps
module rbqm_coef_ram (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Access port
    input  wire [6:0]  addr,
    input  wire        we,
    input  wire [31:0] din,
    output reg  [31:0] dout
);

reg [31:0] mem [0:127];

// Read before write, and register the read word so the core sees a flop output.
always @(posedge pclk)
begin
    if (we)
    begin
        mem[addr] <= din;
    end
end

// Read register has a reset so it shows zero, not an undefined word, until the first clock after reset.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        dout <= 32'h00000000;
    end
    else
    begin
        dout <= mem[addr];
    end
end

endmodule

// ==== hw/rbqm_core.v ====
// Purpose: Record-path biquad bank, channel summer and four-way mixer behind an APB slave.
// Assumes: Four 32-bit signed channels arrive as one frame per in_valid/in_ready transfer.
// Notes:   One shared multiplier walks the enabled sections and all mixer taps in sequence.
//
// Contract
// (RULE1) Twelve second-order sections exist and at most three are applied per channel.
// (RULE2) Each section computes y from N0, 2*N1, N2 on inputs and 2*D1, D2 on outputs over 2^31.
// (RULE3) Reset coefficients make every section pass the signal at unity gain.
// (RULE4) The host loads all coefficients before starting record when it wants filtering.
// (RULE5) Channel one owns a second coefficient bank chosen by a control bit.
// (RULE6) An allocation field of zero bypasses all sections on every channel.
// (RULE7) Allocation 1, 2 or 3 enables sections 1-4, 1-8 or 1-12; section n serves channel (n-1)%4+1.
// (RULE8) Each section owns twenty consecutive byte addresses, six per page from register 8.
// (RULE9) Summing mode replaces every channel with the equally weighted channel sum.
// (RULE10) Output channel one is the scaled sum of all input channels.
// (RULE11) Output channels two to four come from three more mixers with their own scales.
// (RULE12) Each coefficient is one 32-bit signed word in the order N0, N1, N2, D1, D2.
// (RULE13) The bank bit is sampled only at the start of a frame.
`timescale 1ns/1ps
`include "rbqm_map.vh"
module rbqm_core (
    // Clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // APB slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output wire [31:0]  prdata,
    output wire         pready,
    output wire         pslverr,
    // Sample stream in
    input  wire         in_valid,
    input  wire [127:0] in_data,
    output wire         in_ready,
    // Sample stream out
    output wire         out_valid,
    output wire [127:0] out_data
);

localparam ST_INIT = 3'h0;
localparam ST_IDLE = 3'h1;
localparam ST_BQ   = 3'h2;
localparam ST_SUM  = 3'h3;
localparam ST_MIX  = 3'h4;

reg  [2:0]         state_r;
reg  [6:0]         ini_idx_r;
reg  [2:0]         ini_c5_r;
reg  [1:0]         alloc_r;
reg                sum_en_r;
reg                bank_sel_r;
reg                bank_act_r;
reg  [1:0]         stg_r;
reg  [1:0]         ch_r;
reg  [2:0]         cf_r;
reg  [4:0]         mc_r;
reg  signed [67:0] acc_r;
reg  signed [31:0] chv_r [0:3];
reg  signed [31:0] out_r [0:3];
reg  signed [31:0] mix_r [0:3];
reg  signed [31:0] sx1_r [0:11];
reg  signed [31:0] sx2_r [0:11];
reg  signed [31:0] sy1_r [0:11];
reg  signed [31:0] sy2_r [0:11];
reg                in_ready_r;
reg                out_valid_r;
reg                pready_r;
reg                pslverr_r;
reg  [31:0]        prdata_r;
reg                apb_st_r;
wire [31:0]        mem_q;
wire signed [31:0] in_w [0:3];
integer            i;

// Stream lanes: channel k sits in bits 32k+31..32k.
genvar g;
generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
        assign in_w[g] = in_data[32*g+31:32*g];
        assign out_data[32*g+31:32*g] = out_r[g];
    end
endgenerate

assign prdata    = prdata_r;
assign pready    = pready_r;
assign pslverr   = pslverr_r;
assign in_ready  = in_ready_r;
assign out_valid = out_valid_r;

// APB decode: byte register offsets inside a page map to words of the coefficient memory.
wire [4:0] apb_pg   = paddr[11:7];
wire [6:0] apb_off  = paddr[6:0];
wire [6:0] apb_woff = apb_off - `RBQM_BLK_START;
reg  [6:0] apb_idx;
reg        apb_mem;
reg        apb_hit;
always @*
begin
    apb_idx = 7'h00;
    apb_mem = 1'b0;
    if (paddr[11:6] == `RBQM_MIX_PG)
    begin
        apb_mem = 1'b1;
        apb_idx = `RBQM_IDX_MIX + {3'h0, paddr[5:2]};
    end
    else if (apb_off >= `RBQM_BLK_START)
        case (apb_pg)
            `RBQM_PG_A:
            begin
                apb_mem = 1'b1;                                   // [RULE8]
                apb_idx = {2'h0, apb_woff[6:2]};
            end
            `RBQM_PG_B:
            begin
                apb_mem = 1'b1;                                   // [RULE8]
                apb_idx = `RBQM_IDX_PG_B + {2'h0, apb_woff[6:2]};
            end
            `RBQM_PG_ALT:
            begin
                apb_mem = (apb_off < `RBQM_ALT_END);               // [RULE5]
                apb_idx = `RBQM_IDX_ALT + {2'h0, apb_woff[6:2]};
            end
            default: apb_mem = 1'b0;
        endcase
    apb_hit = apb_mem | (paddr == `RBQM_ADDR_CTRL) | (paddr == `RBQM_ADDR_STAT);
end

// Section n (0-based) is stage*4+channel, so channel = n mod 4 falls out of the index.
wire [3:0] sec     = {stg_r, ch_r};                                // [RULE7]
wire [6:0] sec5    = {1'b0, sec, 2'h0} + {3'h0, sec};
wire [6:0] stg5    = {3'h0, stg_r, 2'h0} + {5'h00, stg_r};
wire       use_alt = bank_act_r && (ch_r == 2'h0);
wire [4:0] mcm1    = mc_r - 5'h01;
reg  [6:0] eng_idx;
always @*
begin
    if (state_r == ST_MIX)
        eng_idx = `RBQM_IDX_MIX + {3'h0, mc_r[3:0]};
    else if (use_alt)
        eng_idx = `RBQM_IDX_ALT + stg5 + {4'h0, cf_r};            // [RULE5]
    else
        eng_idx = sec5 + {4'h0, cf_r};                            // [RULE12]
end

// Default image: N0 of every section and the mixer diagonal at unity, all else zero.
wire [6:0]  ini_m   = ini_idx_r - `RBQM_IDX_MIX;
wire        ini_one = (ini_idx_r < `RBQM_IDX_MIX) ? (ini_c5_r == 3'h0) :
                      (ini_m[3:2] == ini_m[1:0]);
wire [31:0] ini_val = ini_one ? `RBQM_UNITY : 32'h00000000;      // [RULE3]

// Memory port: defaults during fill, APB while idle, engine otherwise.
wire        apb_wr   = psel && penable && pready_r && pwrite && apb_mem;
wire        mem_we   = (state_r == ST_INIT) || ((state_r == ST_IDLE) && apb_wr);
wire [31:0] mem_din  = (state_r == ST_INIT) ? ini_val : pwdata;
wire [6:0]  mem_addr = (state_r == ST_INIT) ? ini_idx_r :
                       (state_r == ST_IDLE) ? apb_idx : eng_idx;

rbqm_coef_ram u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .addr    (mem_addr),
    .we      (mem_we),
    .din     (mem_din),
    .dout    (mem_q)
);

// Second operand: the input sample, delay element or mixer channel that pairs with the coefficient read last cycle.
wire [2:0] tap = cf_r - 3'h1;
reg  signed [32:0] opb;
always @*
begin
    if (state_r == ST_MIX)
        opb = {chv_r[mcm1[1:0]][31], chv_r[mcm1[1:0]]};            // [RULE10]
    else
        case (tap)
            3'h0: opb = {chv_r[ch_r][31], chv_r[ch_r]};
            3'h1: opb = {sx1_r[sec], 1'b0};                       // [RULE2]
            3'h2: opb = {sx2_r[sec][31], sx2_r[sec]};
            3'h3: opb = {sy1_r[sec], 1'b0};                       // [RULE2]
            3'h4: opb = {sy2_r[sec][31], sy2_r[sec]};
            default: opb = 33'h000000000;
        endcase
end

// One product per cycle keeps area small; a frame costs about 6 cycles per section.
wire signed [64:0] prod    = $signed(mem_q) * opb;
wire signed [67:0] acc_sum = acc_r + {{3{prod[64]}}, prod};

// Divide by 2^31 and clamp, so a hot filter saturates instead of wrapping.
function [31:0] rbqm_sat;
    input [67:0] a;
    begin
        rbqm_sat = (a[67:62] == 6'h00 || a[67:62] == 6'h3F) ? a[62:31] :
                   (a[67] ? 32'h80000000 : `RBQM_UNITY);
    end
endfunction

wire signed [31:0] yv = rbqm_sat(acc_sum);
wire signed [33:0] csum = {{2{chv_r[0][31]}}, chv_r[0]} + {{2{chv_r[1][31]}}, chv_r[1]} +
                          {{2{chv_r[2][31]}}, chv_r[2]} + {{2{chv_r[3][31]}}, chv_r[3]};

// APB slave: two cycles to fetch, pready for one cycle, writes land at the pready edge.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready_r   <= 1'b0;
        pslverr_r  <= 1'b0;
        prdata_r   <= 32'h00000000;
        apb_st_r   <= 1'b0;
        alloc_r    <= `RBQM_ALLOC_RST;                             // [RULE7]
        sum_en_r   <= 1'b0;
        bank_sel_r <= 1'b0;
    end
    else
    begin
        pready_r  <= 1'b0;
        pslverr_r <= 1'b0;
        if (psel && penable && pready_r)
        begin
            if (pwrite && (paddr == `RBQM_ADDR_CTRL))
            begin
                alloc_r    <= pwdata[`RBQM_ALLOC_HI:`RBQM_ALLOC_LO];  // [RULE6]
                sum_en_r   <= pwdata[`RBQM_SUM_BIT];
                bank_sel_r <= pwdata[`RBQM_BANK_BIT];
            end
        end
        else if (apb_st_r)
        begin
            apb_st_r  <= 1'b0;
            pready_r  <= 1'b1;
            pslverr_r <= !apb_hit;
            if (pwrite || !apb_hit)
                prdata_r <= 32'h00000000;
            else if (apb_mem)
                prdata_r <= mem_q;
            else if (paddr == `RBQM_ADDR_CTRL)
                prdata_r <= {26'h0000000, bank_sel_r, sum_en_r, alloc_r, 2'h0};
            else
                prdata_r <= {29'h00000000, (state_r != ST_INIT), bank_act_r,
                             (state_r != ST_IDLE)};
        end
        else if (psel && penable && (state_r == ST_IDLE))
            apb_st_r <= 1'b1;
    end
end

// Engine: fill defaults, then per frame run sections, summer and mixers.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_r     <= ST_INIT;
        ini_idx_r   <= 7'h00;
        ini_c5_r    <= 3'h0;
        bank_act_r  <= 1'b0;
        stg_r       <= 2'h0;
        ch_r        <= 2'h0;
        cf_r        <= 3'h0;
        mc_r        <= 5'h00;
        acc_r       <= 68'h0;
        in_ready_r  <= 1'b0;
        out_valid_r <= 1'b0;
        for (i = 0; i < 4; i = i + 1)
        begin
            chv_r[i] <= 32'h00000000;
            out_r[i] <= 32'h00000000;
            mix_r[i] <= 32'h00000000;
        end
        for (i = 0; i < `RBQM_NSEC; i = i + 1)
        begin
            sx1_r[i] <= 32'h00000000;
            sx2_r[i] <= 32'h00000000;
            sy1_r[i] <= 32'h00000000;
            sy2_r[i] <= 32'h00000000;
        end
    end
    else
    begin
        out_valid_r <= 1'b0;
        case (state_r)
            ST_INIT:
            begin
                ini_idx_r <= ini_idx_r + 7'h01;
                ini_c5_r  <= (ini_c5_r == `RBQM_LAST_COEF) ? 3'h0 : ini_c5_r + 3'h1;
                if (ini_idx_r == `RBQM_IDX_LAST)
                    state_r <= ST_IDLE;
            end
            ST_IDLE:
            begin
                // Ready drops while APB is selected so the memory port stays with the bus.
                in_ready_r <= !psel && !(in_valid && in_ready_r);
                if (in_valid && in_ready_r)
                begin
                    for (i = 0; i < 4; i = i + 1)
                        chv_r[i] <= in_w[i];
                    bank_act_r <= bank_sel_r;                      // [RULE13]
                    stg_r      <= 2'h0;
                    acc_r      <= 68'h0;
                    state_r    <= (alloc_r == 2'h0) ? ST_SUM : ST_BQ;  // [RULE6]
                end
            end
            ST_BQ:
            begin
                cf_r <= cf_r + 3'h1;
                if (cf_r != 3'h0)
                    acc_r <= acc_sum;                              // [RULE2]
                if (cf_r == `RBQM_NCOEF)
                begin
                    sx2_r[sec] <= sx1_r[sec];
                    sx1_r[sec] <= chv_r[ch_r];
                    sy2_r[sec] <= sy1_r[sec];
                    sy1_r[sec] <= yv;
                    chv_r[ch_r] <= yv;
                    acc_r <= 68'h0;
                    cf_r  <= 3'h0;
                    ch_r  <= ch_r + 2'h1;
                    if (ch_r == 2'h3)
                    begin
                        stg_r <= stg_r + 2'h1;
                        if (stg_r + 2'h1 == alloc_r)
                            state_r <= ST_SUM;                     // [RULE1]
                    end
                end
            end
            ST_SUM:
            begin
                if (sum_en_r)
                    for (i = 0; i < 4; i = i + 1)
                        chv_r[i] <= csum[33:2];                    // [RULE9]
                mc_r    <= 5'h00;
                state_r <= ST_MIX;
            end
            ST_MIX:
            begin
                mc_r <= mc_r + 5'h01;
                if (mc_r != 5'h00)
                begin
                    if (mcm1[1:0] == 2'h3)
                    begin
                        mix_r[mcm1[3:2]] <= yv;                    // [RULE11]
                        acc_r <= 68'h0;
                    end
                    else
                        acc_r <= acc_sum;                          // [RULE10]
                end
                // All four lanes change together, so out_data never shows half a frame.
                if (mc_r == `RBQM_MIX_DONE)
                begin
                    for (i = 0; i < 3; i = i + 1)
                        out_r[i] <= mix_r[i];
                    out_r[3]    <= yv;
                    out_valid_r <= 1'b1;
                    in_ready_r  <= !psel;
                    state_r     <= ST_IDLE;
                end
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

endmodule

// ==== testbench/rbqm_core_sva.sv ====
// Purpose: Port-level protocol checks on the record biquad and mixer core.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Latency bounds cover every allocation value, so no mode input is needed.
`timescale 1ns/1ps
module rbqm_core_sva (
    // Clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // APB slave side
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [31:0]  prdata,
    input  wire         pready,
    input  wire         pslverr,
    // Sample stream
    input  wire         in_valid,
    input  wire         in_ready,
    input  wire         out_valid,
    input  wire [127:0] out_data
);
    default clocking dck @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // APB answer shape and timing.
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stayed high for two cycles");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on a write");
    chk_ready_wait: assert property (psel && !penable |=> !pready [*2] ##[1:200] pready)
        else $error("APB answer too early or never");
    // Stream framing: one pulse per frame, whole frames only.
    chk_out_pulse: assert property (out_valid |=> !out_valid)
        else $error("out_valid longer than one cycle");
    chk_out_hold: assert property (!out_valid && $past(presetn) |-> $stable(out_data))
        else $error("out_data changed without out_valid");
    chk_frame_busy: assert property (in_valid && in_ready |=> !in_ready [*8])
        else $error("new frame accepted mid-computation");
    chk_frame_latency: assert property (in_valid && in_ready |=> !out_valid [*8] ##[1:95] out_valid)
        else $error("frame result outside the latency window");
    chk_psel_holds: assert property (psel ##1 psel |=> !in_ready)
        else $error("stream open while the bus is busy");

    // Main scenarios reached.
    cover property (in_valid && in_ready);
    cover property (out_valid);
    cover property (pslverr);
    cover property (pready && !pwrite);
endmodule

bind rbqm_core rbqm_core_sva rbqm_core_sva_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .out_valid (out_valid),
    .out_data  (out_data)
);

// ==== testbench/rbqm_src.sv ====
// Purpose: Sample source standing in for the decimation stage.
// Assumes: One frame at a time, requested by a go pulse.
// Notes:   Idle lanes carry inverted junk so stale data never looks valid.
`timescale 1ns/1ps
module rbqm_src (
    // Clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // Bench request
    input  wire         go,
    input  wire [127:0] frame,
    // Stream toward the core
    input  wire         in_ready,
    output reg          in_valid,
    output reg  [127:0] in_data
);
    // Hold the frame until the core samples in_ready high, then release it.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_valid <= 1'b0;
            in_data  <= 128'h0;
        end
        else if (go)
        begin
            in_valid <= 1'b1;
            in_data  <= frame;
        end
        else if (in_valid && in_ready)
        begin
            in_valid <= 1'b0;
            in_data  <= ~in_data;
        end
    end
endmodule

// ==== testbench/record_biquad_and_mixer_bench.sv ====
// Purpose: Self-checking bench for the record biquad and mixer core.
// Assumes: Expected samples follow the Q1.31 floor arithmetic of the sections.
// Notes:   Negative samples pass unity stages exactly, so section order is immaterial.
`timescale 1ns/1ps
`include "rbqm_map.vh"
module record_biquad_and_mixer_bench;
    localparam logic [31:0] neg_k  = 32'hFFFFFC00;
    localparam logic [31:0] half_k = 32'h40000000;
    logic               pclk, presetn, psel, penable, pwrite, go, er;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               pready, pslverr, in_valid, in_ready, out_valid;
    logic [127:0]       in_data, out_data, frame, exp;
    logic signed [63:0] p;
    integer             bad_count, check_count, s, k;

    rbqm_core rbqm_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .out_valid(out_valid), .out_data(out_data));
    rbqm_src rbqm_src_i (.pclk(pclk), .presetn(presetn), .go(go), .frame(frame),
        .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));

    // Free-running 25 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task stop_test;
    begin
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    task chk(input logic [127:0] got, input logic [127:0] want);
    begin
        check_count = check_count + 1;
        if (got !== want)
        begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got %h exp %h", $time, got, want);
        end
    end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
    begin
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 400);
        if (pready !== 1'b1)
            chk({127'h0, pready}, 128'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk({96'h0, rd}, {96'h0, e});
    end
    endtask

    // Hand one frame to the source and wait, bounded, for its result.
    task send(input logic [127:0] f);
        integer n;
    begin
        @(posedge pclk);
        go    <= 1'b1;
        frame <= f;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (out_valid !== 1'b1 && n < 300);
        chk({127'h0, out_valid}, 128'h1);
    end
    endtask

    // Byte address of coefficient c of section s.
    function automatic logic [11:0] ca(input integer s, input integer c);
    begin
        ca = (s > 6 ? 12'h480 : 12'h400) + 12'(8 + 20 * ((s - 1) % 6) + 4 * c);
    end
    endfunction

    function automatic logic [127:0] sub4(input logic [127:0] f, input integer n);
        integer i;
    begin
        for (i = 0; i < 4; i = i + 1)
            sub4[32*i+:32] = f[32*i+:32] - 32'(n);
    end
    endfunction

    // Bound on the whole run in case a handshake never completes.
    initial
    begin
        repeat (60000) @(posedge pclk);
        bad_count = bad_count + 1;
        stop_test;
    end

    // Main sequence.
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        go = 1'b0;
        frame = 128'h0;
        bad_count = 0;
        check_count = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`RBQM_ADDR_CTRL, `RBQM_CTRL_RST);
        rdc(ca(1, 0), `RBQM_UNITY);
        rdc(ca(12, 4), 32'h0);
        rdc(12'h600, `RBQM_UNITY);
        rdc(12'h604, 32'h0);
        apb(1'b0, 12'h7FC, 32'h0);
        chk({127'h0, er}, 128'h1);
        apb(1'b1, ca(12, 1), 32'h89ABCDEF);
        rdc(ca(12, 1), 32'h89ABCDEF);
        chk({127'h0, er}, 128'h0);
        apb(1'b1, ca(12, 1), 32'h0);
        // Each active unity section drops a positive sample by one, as does the mixer.
        frame = {32'h7FFF0000, 32'h00003000, 32'h00000200, 32'h00000010};
        for (k = 0; k < 4; k = k + 1)
        begin
            apb(1'b1, `RBQM_ADDR_CTRL, 32'(k << 2));
            send(frame);
            chk(out_data, sub4(frame, k + 1));
        end
        apb(1'b1, `RBQM_ADDR_CTRL, 32'h10);
        send({32'hFFFFFFE0, 32'hFFFFFFF0, 32'hFFFFFFF8, 32'hFFFFFFFC});
        chk(out_data, {4{32'hFFFFFFF1}});
        // Halve one section at a time to see which channel it lands on.
        apb(1'b1, `RBQM_ADDR_CTRL, 32'h0C);
        for (s = 1; s <= 12; s = s + 1)
        begin
            apb(1'b1, ca(s, 0), half_k);
            send({4{neg_k}});
            exp = {4{neg_k}};
            exp[32*((s-1)%4)+:32] = 32'hFFFFFE00;
            chk(out_data, exp);
            apb(1'b1, ca(s, 0), `RBQM_UNITY);
        end
        // Feedback path: clear the state, then y = x/2 + y1/2 over two frames.
        apb(1'b1, `RBQM_ADDR_CTRL, 32'h04);
        send(128'h0);
        apb(1'b1, ca(1, 0), half_k);
        apb(1'b1, ca(1, 3), 32'h20000000);
        send({4{neg_k}});
        chk(out_data, {{3{neg_k}}, 32'hFFFFFE00});
        send({4{neg_k}});
        chk(out_data, {{3{neg_k}}, 32'hFFFFFD00});
        apb(1'b1, ca(1, 0), `RBQM_UNITY);
        apb(1'b1, ca(1, 3), 32'h0);
        // Second bank on channel one, switched in and out between frames.
        apb(1'b1, 12'h508, half_k);
        apb(1'b1, `RBQM_ADDR_CTRL, 32'h24);
        send({4{neg_k}});
        chk(out_data, {{3{neg_k}}, 32'hFFFFFE00});
        rdc(`RBQM_ADDR_STAT, 32'h6);
        apb(1'b1, `RBQM_ADDR_CTRL, 32'h04);
        send({4{neg_k}});
        chk(out_data, {4{neg_k}});
        // Each output also takes half of the next input channel.
        apb(1'b1, `RBQM_ADDR_CTRL, 32'h0);
        for (k = 0; k < 4; k = k + 1)
            apb(1'b1, 12'(12'h600 + 4 * (4 * k + (k + 1) % 4)), half_k);
        frame = {32'hFFFFE000, 32'hFFFFF000, 32'hFFFFF800, neg_k};
        for (k = 0; k < 4; k = k + 1)
        begin
            p = $signed(frame[32*k+:32]) * 64'sh7FFFFFFF
                + $signed(frame[32*((k+1)%4)+:32]) * 64'sh40000000;
            exp[32*k+:32] = p[62:31];
        end
        send(frame);
        chk(out_data, exp);
        stop_test;
    end
endmodule
